// File: rtl/gpwk_pkg.sv
// Constants, offsets and types shared by the port bank with wake-up.
// Assumes a 32-bit AHB-Lite slave decode of the low address byte.
package gpwk_pkg;
   // ----------------------------------------------------------------
   // Pins and ports
   // ----------------------------------------------------------------
   localparam int NPINS = 34;
   localparam int PORT_E = 4;
   localparam int T8_PIN = 6;
   localparam int T16_PIN = 7;
   localparam logic [NPINS-1:0] RST_DATA = 34'h3FFFFFFFF;
   localparam logic [NPINS-1:0] RST_OE = 34'h000000000;
   localparam logic [NPINS-1:0] BYTE_MASK = 34'h0000000FF;
   localparam logic [NPINS-1:0] E_MASK = 34'h300000000;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_PORT_END = 8'h28;
   localparam logic [7:0] OFF_BITOP = 8'h28;
   localparam logic [7:0] OFF_WAKE = 8'h2C;
   localparam logic [7:0] OFF_PDOWN = 8'h30;
   localparam logic [7:0] OFF_T8_CTRL = 8'h34;
   localparam logic [7:0] OFF_T16_CTRL = 8'h38;
   localparam logic [7:0] OFF_T8_CNT = 8'h3C;
   localparam logic [7:0] OFF_T16_CNT = 8'h40;
   localparam logic [7:0] OFF_INT_STAT = 8'h44;
   localparam logic [7:0] OFF_INT_MASK = 8'h48;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int WAKE_W = 22;
   localparam int CTRL_MODE_LSB = 6;
   localparam int CTRL_ON_BIT = 4;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int BITOP_VAL_BIT = 8;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam int INT_W = 3;
   localparam int INT_WAKE = 0;
   localparam int INT_T8 = 1;
   localparam int INT_T16 = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam int T8_W = 8;
   localparam int T16_W = 16;

   typedef enum logic {GPWK_RUN, GPWK_DOWN} gpwk_pwr_t;
endpackage

// File: rtl/gpwk_edge_if.sv
// Synchronised pin levels and their edges, one bit per pin.
// Driven by the synchroniser, read by the port bank.
`timescale 1ns/1ps
`default_nettype none
interface gpwk_edge_if #(parameter int W = 34);
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output level, rise, fall);
   modport dst (input level, rise, fall);
endinterface
`default_nettype wire

// File: rtl/gpwk_sync.sv
// Two-stage pin synchroniser with rising and falling edge detection.
// Assumes pins change asynchronously to hclk.
`timescale 1ns/1ps
`default_nettype none
module gpwk_sync #(parameter int W = 34) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   gpwk_edge_if.src edges
);
   logic [W-1:0] meta;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // ----------------------------------------------------------------
   // Synchroniser and edge history
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= '1;
         stage2 <= '1;
         stage3 <= '1;
      end else begin
         meta <= d;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   assign edges.level = stage2;
   assign edges.rise = stage2 & ~stage3;
   assign edges.fall = ~stage2 & stage3;

   a_fall_after_sync: assert property (@(posedge hclk) disable iff (!hresetn)
      edges.fall == ($past(d, 3) & ~$past(d, 2)))
      else $error("falling edge not seen two stages after pin");
endmodule
`default_nettype wire

// File: rtl/gpwk_evcnt.sv
// Event counter stepped by one selected edge of a shared pin.
// Assumes rise and fall are single-cycle pulses from the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module gpwk_evcnt #(parameter int W = 8) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic en,
   input wire logic edge_sel,
   input wire logic rise,
   input wire logic fall,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic [W-1:0] count,
   output logic ovf
);
   logic step;

   // Low edge-select counts rising edges, high counts falling edges
   assign step = en && (edge_sel ? fall : rise);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
         ovf <= 1'b0;
      end else begin
         ovf <= step && !load && (&count);
         if (load) begin
            count <= load_val;
         end else if (step) begin
            count <= count + 1'b1;
         end
      end
   end

   a_count_one_step: assert property (@(posedge hclk) disable iff (!hresetn)
      step && !load |=> count == $past(count) + 1'b1)
      else $error("counter did not advance by one on its edge");
   a_count_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      !step && !load |=> $stable(count))
      else $error("counter moved without an active edge");
endmodule
`default_nettype wire

// File: rtl/gpwk_top.sv
// Port bank with direction control, bit operations, pin wake-up and
// two shared event-count pins, reached over AHB-Lite.
// Assumes a single master, single word transfers, hclk always running.
//
// What this block does
// - Writing the power-down command stops the system clock until wake-up.
// - Power-down lasts until an enabled pin falls high to low.
// - Every pin of ports A to D and both E pins can wake.
// - Wake enables are per nibble on ports A and B, per bit elsewhere.
// - Any number of pins may be wake sources together.
// - One direction bit per pin, writable at any time.
// - Direction one makes an input; reads return the pin level.
// - Direction zero makes an output driven from its data latch.
// - Reading an output bit returns the latch, not the pin.
// - Reset sets every data latch and direction bit to one.
// - A pin turned output before any data write drives high.
// - Bit set or clear reads the whole port and writes it back.
// - Port A bit 6 is the 8-bit counter's event input when selected.
// - Port A bit 7 is the 16-bit counter's event input when selected.
// - Each selected edge advances the event counter by exactly one; a count write in the same cycle wins and the edge is lost.
// - Latches hold until rewritten; inputs are sampled at the read.
`timescale 1ns/1ps
`default_nettype none
module gpwk_top
   import gpwk_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic clock_stop,
   output logic irq
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [5:0] port_base(input logic [2:0] p);
      case (p)
         3'h0: port_base = 6'h00;
         3'h1: port_base = 6'h08;
         3'h2: port_base = 6'h10;
         3'h3: port_base = 6'h18;
         default: port_base = 6'h20;
      endcase
   endfunction

   function automatic logic [NPINS-1:0] port_mask(input logic [2:0] p);
      port_mask = (p == 3'(PORT_E)) ? E_MASK : (BYTE_MASK << port_base(p));
   endfunction

   // Output bits give the latch, input bits the live pin
   function automatic logic [7:0] port_read(input logic [2:0] p,
         input logic [NPINS-1:0] lat, input logic [NPINS-1:0] oe,
         input logic [NPINS-1:0] pin);
      logic [NPINS-1:0] merged;
      merged = (oe & lat) | (~oe & pin);
      port_read = 8'(((merged & port_mask(p)) >> port_base(p)));
   endfunction

   // Nibble enables for ports A and B, bit enables for C, D, E
   function automatic logic [NPINS-1:0] wake_expand(input logic [WAKE_W-1:0] w);
      wake_expand = {w[21:4], {4{w[3]}}, {4{w[2]}}, {4{w[1]}}, {4{w[0]}}};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   gpwk_edge_if #(.W(NPINS)) edges ();
   gpwk_pwr_t pwr;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [WAKE_W-1:0] wake_en;
   logic [7:0] t8_ctrl;
   logic [7:0] t16_ctrl;
   logic [INT_W-1:0] int_stat;
   logic [INT_W-1:0] int_mask;
   logic [INT_W-1:0] int_set;
   logic [INT_W-1:0] int_clr;
   logic [INT_W-1:0] next_int_stat;
   logic [T8_W-1:0] t8_count;
   logic [T16_W-1:0] t16_count;
   logic t8_ovf;
   logic t16_ovf;
   logic rd_take;
   logic wr_take;
   logic wake_hit;
   logic [31:0] next_rdata;
   logic [2:0] wr_port;
   logic [2:0] bit_port;
   logic [2:0] bit_idx;
   logic bit_ok;
   logic [NPINS-1:0] bit_word;
   logic [NPINS-1:0] wr_word;

   gpwk_sync #(.W(NPINS)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(pin_in),
      .edges(edges)
   );

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   assign rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
   assign wr_port = wr_addr[5:3];

   always_comb begin
      next_rdata = 32'h00000000;
      if (haddr[7:0] < OFF_PORT_END) begin
         if (haddr[2]) begin
            next_rdata[7:0] = 8'(((~pin_oe & port_mask(haddr[5:3])) >> port_base(haddr[5:3])));
         end else begin
            next_rdata[7:0] = port_read(haddr[5:3], pin_out, pin_oe, pin_in);
         end
      end else begin
         case (haddr[7:0])
            OFF_WAKE: next_rdata[WAKE_W-1:0] = wake_en;
            OFF_PDOWN: next_rdata[0] = (pwr == GPWK_DOWN);
            OFF_T8_CTRL: next_rdata[7:0] = t8_ctrl;
            OFF_T16_CTRL: next_rdata[7:0] = t16_ctrl;
            OFF_T8_CNT: next_rdata[T8_W-1:0] = t8_count;
            OFF_T16_CNT: next_rdata[T16_W-1:0] = t16_count;
            OFF_INT_STAT: next_rdata[INT_W-1:0] = int_stat;
            OFF_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= wr_take;
         if (wr_take) begin
            wr_addr <= haddr[7:0];
         end
         if (rd_take) begin
            hrdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data latches and directions
   // ----------------------------------------------------------------
   assign bit_port = hwdata[6:4];
   assign bit_idx = hwdata[2:0];
   assign bit_ok = bit_port < 3'(PORT_E) || (bit_port == 3'(PORT_E) && bit_idx < 3'h2);

   always_comb begin
      bit_word = {26'h0, port_read(bit_port, pin_out, pin_oe, pin_in)};
      bit_word[bit_idx] = hwdata[BITOP_VAL_BIT];
      wr_word = {26'h0, hwdata[7:0]};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= RST_DATA;
      end else if (wr_pend && wr_addr < OFF_PORT_END && !wr_addr[2]) begin
         pin_out <= (pin_out & ~port_mask(wr_port))
            | ((wr_word << port_base(wr_port)) & port_mask(wr_port));
      end else if (wr_pend && wr_addr == OFF_BITOP && bit_ok) begin
         pin_out <= (pin_out & ~port_mask(bit_port))
            | ((bit_word << port_base(bit_port)) & port_mask(bit_port));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_oe <= RST_OE;
      end else if (wr_pend && wr_addr < OFF_PORT_END && wr_addr[2]) begin
         pin_oe <= (pin_oe & ~port_mask(wr_port))
            | ((~wr_word << port_base(wr_port)) & port_mask(wr_port));
      end
   end

   // ----------------------------------------------------------------
   // Power-down and wake-up
   // ----------------------------------------------------------------
   assign wake_hit = |(edges.fall & wake_expand(wake_en));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_en <= '0;
      end else if (wr_pend && wr_addr == OFF_WAKE) begin
         wake_en <= hwdata[WAKE_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr <= GPWK_RUN;
         clock_stop <= 1'b0;
      end else begin
         case (pwr)
            GPWK_RUN: begin
               if (wr_pend && wr_addr == OFF_PDOWN && hwdata[0]) begin
                  pwr <= GPWK_DOWN;
                  clock_stop <= 1'b1;
               end
            end
            GPWK_DOWN: begin
               if (wake_hit) begin
                  pwr <= GPWK_RUN;
                  clock_stop <= 1'b0;
               end
            end
            default: begin
               pwr <= GPWK_RUN;
               clock_stop <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shared event-count pins
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t8_ctrl <= RST_CTRL;
         t16_ctrl <= RST_CTRL;
      end else if (wr_pend && wr_addr == OFF_T8_CTRL) begin
         t8_ctrl <= hwdata[7:0];
      end else if (wr_pend && wr_addr == OFF_T16_CTRL) begin
         t16_ctrl <= hwdata[7:0];
      end
   end

   gpwk_evcnt #(.W(T8_W)) u_t8 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(t8_ctrl[CTRL_ON_BIT] && t8_ctrl[CTRL_MODE_LSB+:2] == MODE_EVENT),
      .edge_sel(t8_ctrl[CTRL_EDGE_BIT]),
      .rise(edges.rise[T8_PIN]),
      .fall(edges.fall[T8_PIN]),
      .load(wr_pend && wr_addr == OFF_T8_CNT),
      .load_val(hwdata[T8_W-1:0]),
      .count(t8_count),
      .ovf(t8_ovf)
   );

   gpwk_evcnt #(.W(T16_W)) u_t16 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(t16_ctrl[CTRL_ON_BIT] && t16_ctrl[CTRL_MODE_LSB+:2] == MODE_EVENT),
      .edge_sel(t16_ctrl[CTRL_EDGE_BIT]),
      .rise(edges.rise[T16_PIN]),
      .fall(edges.fall[T16_PIN]),
      .load(wr_pend && wr_addr == OFF_T16_CNT),
      .load_val(hwdata[T16_W-1:0]),
      .count(t16_count),
      .ovf(t16_ovf)
   );

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_comb begin
      int_set = '0;
      int_set[INT_WAKE] = (pwr == GPWK_DOWN) && wake_hit;
      int_set[INT_T8] = t8_ovf;
      int_set[INT_T16] = t16_ovf;
      int_clr = (wr_pend && wr_addr == OFF_INT_STAT) ? hwdata[INT_W-1:0] : '0;
      next_int_stat = (int_stat & ~int_clr) | int_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_stat <= '0;
         int_mask <= '0;
         irq <= 1'b0;
      end else begin
         int_stat <= next_int_stat;
         irq <= |(next_int_stat & (wr_pend && wr_addr == OFF_INT_MASK ?
            hwdata[INT_W-1:0] : int_mask));
         if (wr_pend && wr_addr == OFF_INT_MASK) begin
            int_mask <= hwdata[INT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic after_reset;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         after_reset <= 1'b1;
      end else begin
         after_reset <= 1'b0;
      end
   end

   sequence s_read_port_a;
      rd_take && haddr[7:0] == 8'h00;
   endsequence

   sequence s_pdown_cmd;
      wr_pend && wr_addr == OFF_PDOWN && hwdata[0] && pwr == GPWK_RUN;
   endsequence

   a_reset_all_high: assert property (@(posedge hclk) disable iff (!hresetn)
      after_reset |-> pin_out == RST_DATA && pin_oe == RST_OE)
      else $error("ports not all high inputs after reset");
   a_read_out_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      s_read_port_a |=> ((hrdata[7:0] ^ $past(pin_out[7:0])) & $past(pin_oe[7:0])) == 8'h00)
      else $error("output bit read did not return its latch");
   a_read_in_pin: assert property (@(posedge hclk) disable iff (!hresetn)
      s_read_port_a |=> ((hrdata[7:0] ^ $past(pin_in[7:0])) & ~$past(pin_oe[7:0])) == 8'h00)
      else $error("input bit read did not return the pin");
   a_enter_down: assert property (@(posedge hclk) disable iff (!hresetn)
      s_pdown_cmd |=> clock_stop ##0 pwr == GPWK_DOWN)
      else $error("power-down command did not stop the clock");
   a_stay_down: assert property (@(posedge hclk) disable iff (!hresetn)
      pwr == GPWK_DOWN && !wake_hit |=> clock_stop)
      else $error("left power-down without a wake edge");
   a_wake_up: assert property (@(posedge hclk) disable iff (!hresetn)
      pwr == GPWK_DOWN && wake_hit |=> !clock_stop && int_stat[INT_WAKE])
      else $error("enabled falling edge did not wake the device");
   a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      !wr_pend |=> $stable(pin_out) && $stable(pin_oe))
      else $error("port latch changed without a write");
   a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == (|(int_stat & int_mask)))
      else $error("unmasked status bit without interrupt");
endmodule
`default_nettype wire

// File: testbench/gpwk_pins_model.sv
// External switches and loads on the 34 port pins.
// Assumes the bench changes switch levels right after a rising hclk edge.
`timescale 1ns/1ps
`default_nettype none
module gpwk_pins_model
   import gpwk_pkg::*;
(
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe,
   input wire logic [NPINS-1:0] sw,
   input wire logic [NPINS-1:0] clash,
   output logic [NPINS-1:0] pin_in
);
   // ----------------------------------------------------------------
   // Pin level
   // ----------------------------------------------------------------
   // Driven pins follow the latch unless an overload is commanded
   assign pin_in = (pin_oe & ~clash & pin_out) | ((~pin_oe | clash) & sw);
endmodule
`default_nettype wire

// File: testbench/test_gpwk_top.sv
// Self-checking bench for the port bank with wake-up and event pins.
// Assumes one AHB-Lite master with zero-wait slave and a pin model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_gpwk_top
   import gpwk_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, clock_stop, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [NPINS-1:0] pin_in, pin_out, pin_oe, sw, clash;
   int mismatches, cmp_count;
   // ----------------------------------------------------------------
   // Instances
   // ----------------------------------------------------------------
   gpwk_top u_gpwk_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .clock_stop(clock_stop),
      .irq(irq));
   gpwk_pins_model u_gpwk_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .sw(sw),
      .clash(clash), .pin_in(pin_in));
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n == 50) `CHK("hreadyout", 1'b1, hreadyout)
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h00000000, q);
      `CHK(n, e, q)
   endtask
   task automatic pulse(input int p, input int n);
      repeat (n) begin
         sw[p] <= 1'b0;
         repeat (4) @(posedge hclk);
         sw[p] <= 1'b1;
         repeat (4) @(posedge hclk);
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      `CHK("pin_oe", RST_OE, pin_oe)
      `CHK("pin_out", RST_DATA, pin_out)
      for (int p = 0; p < 5; p++) begin
         chk_reg("dir", 8'(p * 8 + 4), p == PORT_E ? 32'h3 : 32'hFF);
         chk_reg("data", 8'(p * 8), 32'(sw >> (p * 8)) & 32'hFF);
      end
      sw[3:0] <= 4'hA;
      chk_reg("sampled", 8'h00, 32'h000000FA);
      sw[3:0] <= 4'hF;
   endtask
   task automatic t_dir();
      wr(8'h04, 32'h0000000F);
      @(posedge hclk);
      `CHK("oe A", 8'hF0, pin_oe[7:0])
      `CHK("out A", 8'hFF, pin_out[7:0])
      wr(8'h00, 32'h00000055);
      @(posedge hclk);
      `CHK("out A", 8'h55, pin_out[7:0])
      clash[7:0] <= 8'hFF;
      sw[7:0] <= 8'hA3;
      chk_reg("read A", 8'h00, 32'h00000053);
      repeat (20) @(posedge hclk);
      `CHK("hold A", 8'h55, pin_out[7:0])
      clash <= '0;
      sw[7:0] <= 8'hFF;
      wr(8'h04, 32'h000000FF);
   endtask
   task automatic t_bitop();
      wr(8'h0C, 32'h000000F0);
      wr(8'h08, 32'h00000000);
      sw[15:8] <= 8'h6F;
      wr(OFF_BITOP, 32'h00000111);
      @(posedge hclk);
      `CHK("set B1", 8'h62, pin_out[15:8])
      wr(OFF_BITOP, 32'h00000016);
      wr(OFF_BITOP, 32'h00000151);
      @(posedge hclk);
      `CHK("clr B6", 8'h22, pin_out[15:8])
      chk_reg("bitop", OFF_BITOP, 32'h00000000);
      sw[15:8] <= 8'hFF;
      wr(8'h0C, 32'h000000FF);
   endtask
   task automatic t_wake();
      int pins [5];
      pins = '{2, 13, 20, 30, 33};
      wr(OFF_WAKE, 32'h003FFFFF);
      foreach (pins[i]) begin
         wr(OFF_PDOWN, 32'h00000001);
         @(posedge hclk);
         `CHK("down", 1'b1, clock_stop)
         sw[pins[i]] <= 1'b0;
         repeat (2) @(posedge hclk);
         `CHK("still down", 1'b1, clock_stop)
         repeat (3) @(posedge hclk);
         `CHK("woken", 1'b0, clock_stop)
         sw[pins[i]] <= 1'b1;
         repeat (4) @(posedge hclk);
      end
      wr(OFF_WAKE, 32'h00000001);
      wr(OFF_PDOWN, 32'h00000001);
      pulse(5, 1);
      `CHK("nibble off", 1'b1, clock_stop)
      chk_reg("pdown", OFF_PDOWN, 32'h00000001);
      pulse(3, 1);
      `CHK("nibble on", 1'b0, clock_stop)
      chk_reg("stat", OFF_INT_STAT, 32'h00000001);
      `CHK("irq masked", 1'b0, irq)
      wr(OFF_INT_MASK, 32'h00000001);
      repeat (2) @(posedge hclk);
      `CHK("irq", 1'b1, irq)
      wr(OFF_INT_STAT, 32'h00000001);
      repeat (2) @(posedge hclk);
      `CHK("irq clr", 1'b0, irq)
      pulse(3, 1);
      chk_reg("stat run", OFF_INT_STAT, 32'h00000000);
   endtask
   task automatic t_count();
      wr(OFF_T8_CTRL, 32'h00000010);
      wr(OFF_T8_CNT, 32'h000000FE);
      pulse(T8_PIN, 2);
      chk_reg("t8 timer", OFF_T8_CNT, 32'h000000FE);
      wr(OFF_T8_CTRL, 32'h00000050);
      pulse(T8_PIN, 2);
      pulse(T16_PIN, 1);
      sw[T8_PIN] <= 1'b0;
      repeat (4) @(posedge hclk);
      chk_reg("t8 fall", OFF_T8_CNT, 32'h00000000);
      sw[T8_PIN] <= 1'b1;
      repeat (4) @(posedge hclk);
      chk_reg("t8 rise", OFF_T8_CNT, 32'h00000001);
      chk_reg("ovf8", OFF_INT_STAT, 32'h00000002);
      wr(OFF_T16_CTRL, 32'h00000058);
      wr(OFF_T16_CNT, 32'h0000FFFE);
      sw[T16_PIN] <= 1'b0;
      repeat (4) @(posedge hclk);
      chk_reg("t16 fall", OFF_T16_CNT, 32'h0000FFFF);
      sw[T16_PIN] <= 1'b1;
      pulse(T8_PIN, 1);
      pulse(T16_PIN, 1);
      chk_reg("t16", OFF_T16_CNT, 32'h00000000);
      chk_reg("ovf16", OFF_INT_STAT, 32'h00000006);
   endtask
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      #(100 * 20000);
      mismatches++;
      stop_test();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      sw = '1;
      clash = '0;
      mismatches = 0;
      cmp_count = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_dir();
      t_bitop();
      t_wake();
      t_count();
      stop_test();
   end
endmodule
`default_nettype wire
